// ### inc/mrd_params.svh
`ifndef MRD_PARAMS_SVH
`define MRD_PARAMS_SVH
`define MRD_INSTR_W      14
`define MRD_DATA_W       8
`define MRD_FADDR_W      7
`define MRD_LIT8_W       8
`define MRD_LIT11_W      11
`define MRD_PHASES       4
`define MRD_DEST_BIT     7
`define MRD_BIT_LSB      7
`define MRD_CLS_MSB      13
`define MRD_TIMER_ZERO_COUNT_ADDR    7'h01
`define MRD_PORT2_ADDR   7'h06
`define MRD_NOP_WORD     14'h0000
`endif

// ### inc/mrd_pkg.sv
package mrd_pkg;
   typedef enum logic [1:0] {
      MRD_CLS_BYTE = 2'b00,
      MRD_CLS_BIT  = 2'b01,
      MRD_CLS_JUMP = 2'b10,
      MRD_CLS_LIT  = 2'b11
   } mrd_cls_t;
   typedef enum logic [4:0] {
      MRD_OP_NOP = 5'h00, MRD_OP_MOVWF = 5'h01, MRD_OP_CLEAR_FILE_INSTR = 5'h02, MRD_OP_CLRW = 5'h03,
      MRD_OP_SUBWF = 5'h04, MRD_OP_DECF = 5'h05, MRD_OP_IORWF = 5'h06, MRD_OP_ANDWF = 5'h07,
      MRD_OP_XORWF = 5'h08, MRD_OP_ADDWF = 5'h09, MRD_OP_MOVF = 5'h0A, MRD_OP_COMF = 5'h0B,
      MRD_OP_INCF = 5'h0C, MRD_OP_DECFSZ = 5'h0D, MRD_OP_RRF = 5'h0E, MRD_OP_RLF = 5'h0F,
      MRD_OP_SWAPF = 5'h10, MRD_OP_INCFSZ = 5'h11, MRD_OP_BCF = 5'h12, MRD_OP_BSF = 5'h13,
      MRD_OP_BTFSC = 5'h14, MRD_OP_BTFSS = 5'h15, MRD_OP_CALL = 5'h16, MRD_OP_GOTO = 5'h17,
      MRD_OP_MOVLW = 5'h18, MRD_OP_RETLW = 5'h19, MRD_OP_IORLW = 5'h1A, MRD_OP_ANDLW = 5'h1B,
      MRD_OP_XORLW = 5'h1C, MRD_OP_SUBLW = 5'h1D, MRD_OP_ADDLW = 5'h1E, MRD_OP_CTRL = 5'h1F
   } mrd_op_t;
   typedef enum logic [1:0] {
      MRD_PH_Q1 = 2'b00,
      MRD_PH_Q2 = 2'b01,
      MRD_PH_Q3 = 2'b10,
      MRD_PH_Q4 = 2'b11
   } mrd_phase_t;
endpackage

// ### inc/mrd_dec_if.sv
interface mrd_dec_if;
   import mrd_pkg::*;
   logic [13:0] word;
   mrd_cls_t    cls;
   mrd_op_t     op;
   logic [6:0]  faddr;
   logic        dest_f;
   logic [2:0]  bitsel;
   logic [10:0] lit;
   logic        uses_file;
   logic        writes_file;
   logic        writes_w;
   logic        is_skip_test;
   logic        is_branch;
   logic        is_legal;
   modport dec (input word, output cls, op, faddr, dest_f, bitsel, lit, uses_file,
                writes_file, writes_w, is_skip_test, is_branch, is_legal);
   modport use_side (output word, input cls, op, faddr, dest_f, bitsel, lit, uses_file,
                     writes_file, writes_w, is_skip_test, is_branch, is_legal);
endinterface

// ### hw/mrd_field_dec.sv
`include "mrd_params.svh"
module mrd_field_dec
   import mrd_pkg::*;
(
   mrd_dec_if.dec d
);
   wire [1:0] top2   = d.word[13:12];
   wire [3:0] mid4   = d.word[11:8];
   wire [7:0] low8   = d.word[7:0];
   wire       dbit   = d.word[`MRD_DEST_BIT];
   mrd_op_t   op_c;

   // per-class sub-decode of all four classes; x positions never reach the compare
   always_comb begin
      op_c = MRD_OP_NOP;
      case (top2)
         2'b00: begin
            case (mid4)
               4'h0:    op_c = dbit ? MRD_OP_MOVWF : MRD_OP_CTRL;
               4'h1:    op_c = dbit ? MRD_OP_CLEAR_FILE_INSTR : MRD_OP_CLRW;
               4'h2:    op_c = MRD_OP_SUBWF;
               4'h3:    op_c = MRD_OP_DECF;
               4'h4:    op_c = MRD_OP_IORWF;
               4'h5:    op_c = MRD_OP_ANDWF;
               4'h6:    op_c = MRD_OP_XORWF;
               4'h7:    op_c = MRD_OP_ADDWF;
               4'h8:    op_c = MRD_OP_MOVF;
               4'h9:    op_c = MRD_OP_COMF;
               4'hA:    op_c = MRD_OP_INCF;
               4'hB:    op_c = MRD_OP_DECFSZ;
               4'hC:    op_c = MRD_OP_RRF;
               4'hD:    op_c = MRD_OP_RLF;
               4'hE:    op_c = MRD_OP_SWAPF;
               default: op_c = MRD_OP_INCFSZ;
            endcase
         end
         2'b01: begin
            case (mid4[3:2])
               2'b00:   op_c = MRD_OP_BCF;
               2'b01:   op_c = MRD_OP_BSF;
               2'b10:   op_c = MRD_OP_BTFSC;
               default: op_c = MRD_OP_BTFSS;
            endcase
         end
         2'b10:   op_c = mid4[3] ? MRD_OP_GOTO : MRD_OP_CALL;
         default: begin
            case (mid4[3:1])
               3'b000, 3'b001: op_c = MRD_OP_MOVLW;
               3'b010, 3'b011: op_c = MRD_OP_RETLW;
               3'b100:  op_c = mid4[0] ? MRD_OP_ANDLW : MRD_OP_IORLW;
               3'b101:  op_c = mid4[0] ? MRD_OP_CTRL : MRD_OP_XORLW;
               3'b110:  op_c = MRD_OP_SUBLW;
               default: op_c = MRD_OP_ADDLW;
            endcase
         end
      endcase
   end

   // control group (mid4 = 0, d = 0): nop, return, retfie, sleep, clear-watchdog
   wire ctrl_nop   = (low8[6:0] == 7'h00) || (low8 == 8'h20) || (low8 == 8'h40)
                     || (low8 == 8'h60);
   wire ctrl_ret   = (low8 == 8'h08) || (low8 == 8'h09);
   wire ctrl_known = ctrl_nop || ctrl_ret || (low8 == 8'h63) || (low8 == 8'h64);
   wire lit_hole   = (top2 == 2'b11) && (mid4 == 4'hB);

   assign d.op     = ((op_c == MRD_OP_CTRL) && ctrl_nop) ? MRD_OP_NOP : op_c;
   assign d.cls    = mrd_cls_t'(top2);
   assign d.faddr  = d.word[`MRD_FADDR_W-1:0];
   assign d.dest_f = (top2 == 2'b00) ? dbit : 1'b0;
   assign d.bitsel = d.word[`MRD_BIT_LSB+2:`MRD_BIT_LSB];
   assign d.lit    = (top2 == 2'b10) ? d.word[10:0] : {3'h0, low8};
   assign d.uses_file    = (top2 == 2'b01) ||
                           ((top2 == 2'b00) && (mid4 != 4'h0 || dbit) && d.op != MRD_OP_CLRW);
   assign d.writes_file  = (top2 == 2'b00) ? (dbit && mid4 != 4'h0 ? 1'b1 :
                            d.op == MRD_OP_MOVWF) : (top2 == 2'b01 && !mid4[3]);
   assign d.writes_w     = ((top2 == 2'b00) && !dbit && mid4 != 4'h0) ||
                           ((top2 == 2'b11) && !lit_hole);
   assign d.is_skip_test = (d.op == MRD_OP_DECFSZ) || (d.op == MRD_OP_INCFSZ) ||
                           (d.op == MRD_OP_BTFSC) || (d.op == MRD_OP_BTFSS);
   assign d.is_branch    = (top2 == 2'b10) || (d.op == MRD_OP_RETLW) ||
                           ((op_c == MRD_OP_CTRL) && ctrl_ret);
   assign d.is_legal     = !lit_hole && ((op_c != MRD_OP_CTRL) || ctrl_known);
endmodule

// ### hw/mrd_core_seq.sv
`include "mrd_params.svh"
module mrd_core_seq
   import mrd_pkg::*;
#(
   parameter int PC_W = 13
) (
   // clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   // program memory
   input  wire logic [13:0]   i_instr,
   output logic [PC_W-1:0]    o_pc,
   // file register port
   input  wire logic [7:0]    i_file_rdata,
   input  wire logic [7:0]    i_port_pins,
   input  wire logic          i_psa_to_wdt,
   input  wire logic [PC_W-1:0] i_ret_addr,
   output logic [6:0]         o_file_addr,
   output logic               o_file_rd,
   output logic               o_file_wr,
   output logic [7:0]         o_file_wdata,
   output logic               o_port_read,
   output logic               o_prescale_clr,
   // status
   output logic [7:0]         o_wreg,
   output logic               o_carry,
   output logic               o_zero,
   output logic [1:0]         o_class,
   output logic               o_skip_cycle,
   output logic               o_illegal,
   output logic [1:0]         o_phase
);
   // jump targets keep at least one page bit above the eleven-bit field
   if (PC_W < 12 || PC_W > 16) begin : g_pc_w_check
      $error("mrd_core_seq: PC_W out of range");
   end

   mrd_dec_if dif ();
   mrd_field_dec u_dec (.d(dif.dec));

   logic [13:0]     ir_r;
   logic [13:0]     ir_nxt;
   mrd_phase_t      ph_r;
   logic            flush_r;
   logic            flush_nxt;
   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] pc_nxt;
   logic [7:0]      opnd_r;
   logic [7:0]      w_r;
   logic            c_r;
   logic            z_r;

   assign dif.word = ir_r;

   // file address is operand bits 6..0; io port reads come from the pins
   wire       is_port  = (dif.faddr == `MRD_PORT2_ADDR);
   wire [7:0] rd_val   = is_port ? i_port_pins : i_file_rdata;
   wire [7:0] bmask    = 8'h01 << dif.bitsel;
   wire [7:0] k8       = dif.lit[7:0];
   wire [8:0] add_wf   = {1'b0, opnd_r} + {1'b0, w_r};
   wire [8:0] sub_wf   = {1'b0, opnd_r} + {1'b0, ~w_r} + 9'h001;
   wire [8:0] add_lw   = {1'b0, k8} + {1'b0, w_r};
   wire [8:0] sub_lw   = {1'b0, k8} + {1'b0, ~w_r} + 9'h001;
   wire       bit_val  = |(opnd_r & bmask);
   logic [7:0] res;
   logic       res_c;
   logic       upd_z;
   logic       upd_c;

   // modify step on the operand captured in Q2
   always_comb begin
      res   = opnd_r;
      res_c = c_r;
      upd_z = 1'b0;
      upd_c = 1'b0;
      case (dif.op)
         MRD_OP_MOVWF:  res = w_r;
         MRD_OP_CLEAR_FILE_INSTR, MRD_OP_CLRW: begin res = 8'h00; upd_z = 1'b1; end
         MRD_OP_SUBWF:  begin res = sub_wf[7:0]; res_c = sub_wf[8]; upd_z = 1'b1; upd_c = 1'b1; end
         MRD_OP_ADDWF:  begin res = add_wf[7:0]; res_c = add_wf[8]; upd_z = 1'b1; upd_c = 1'b1; end
         MRD_OP_DECF, MRD_OP_DECFSZ: begin res = opnd_r - 8'h01; upd_z = !dif.is_skip_test; end
         MRD_OP_INCF, MRD_OP_INCFSZ: begin res = opnd_r + 8'h01; upd_z = !dif.is_skip_test; end
         MRD_OP_IORWF:  begin res = opnd_r | w_r; upd_z = 1'b1; end
         MRD_OP_ANDWF:  begin res = opnd_r & w_r; upd_z = 1'b1; end
         MRD_OP_XORWF:  begin res = opnd_r ^ w_r; upd_z = 1'b1; end
         MRD_OP_MOVF:   upd_z = 1'b1;
         MRD_OP_COMF:   begin res = ~opnd_r; upd_z = 1'b1; end
         MRD_OP_RRF:    begin res = {c_r, opnd_r[7:1]}; res_c = opnd_r[0]; upd_c = 1'b1; end
         MRD_OP_RLF:    begin res = {opnd_r[6:0], c_r}; res_c = opnd_r[7]; upd_c = 1'b1; end
         MRD_OP_SWAPF:  res = {opnd_r[3:0], opnd_r[7:4]};
         MRD_OP_BCF:    res = opnd_r & ~bmask;
         MRD_OP_BSF:    res = opnd_r | bmask;
         MRD_OP_MOVLW, MRD_OP_RETLW: res = k8;
         MRD_OP_IORLW:  begin res = k8 | w_r; upd_z = 1'b1; end
         MRD_OP_ANDLW:  begin res = k8 & w_r; upd_z = 1'b1; end
         MRD_OP_XORLW:  begin res = k8 ^ w_r; upd_z = 1'b1; end
         MRD_OP_SUBLW:  begin res = sub_lw[7:0]; res_c = sub_lw[8]; upd_z = 1'b1; upd_c = 1'b1; end
         MRD_OP_ADDLW:  begin res = add_lw[7:0]; res_c = add_lw[8]; upd_z = 1'b1; upd_c = 1'b1; end
         default:       res = opnd_r;
      endcase
   end

   // two-cycle condition: taken skip or any program counter change
   wire skip_taken = (dif.op == MRD_OP_DECFSZ || dif.op == MRD_OP_INCFSZ) ? (res == 8'h00) :
                     (dif.op == MRD_OP_BTFSC) ? !bit_val :
                     (dif.op == MRD_OP_BTFSS) ? bit_val : 1'b0;
   wire two_cyc    = skip_taken || dif.is_branch;
   wire live       = !flush_r && dif.is_legal;
   wire at_q4      = (ph_r == MRD_PH_Q4);
   wire at_q2      = (ph_r == MRD_PH_Q2);
   wire do_read    = at_q2 && live && dif.uses_file;
   wire do_write   = at_q4 && live && dif.writes_file;
   wire do_wreg    = at_q4 && live && dif.writes_w;
   wire [PC_W-1:0] pc_inc = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
   wire [PC_W-1:0] pc_jmp = {pc_r[PC_W-1:11], dif.lit};

   // next program counter and prefetched word, resolved at the end of Q4
   always_comb begin
      pc_nxt    = pc_r;
      ir_nxt    = ir_r;
      flush_nxt = flush_r;
      if (at_q4) begin
         ir_nxt    = i_instr;
         flush_nxt = live && two_cyc;
         pc_nxt    = pc_inc;
         if (live && dif.cls == MRD_CLS_JUMP) begin
            pc_nxt = pc_jmp;
         end else if (live && dif.is_branch) begin
            pc_nxt = i_ret_addr;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ph_r    <= MRD_PH_Q1;
         ir_r    <= `MRD_NOP_WORD;
         flush_r <= 1'b1;
         pc_r    <= '0;
      end else begin
         ph_r    <= mrd_phase_t'(ph_r + 2'b01);
         ir_r    <= ir_nxt;
         flush_r <= flush_nxt;
         pc_r    <= pc_nxt;
      end
   end

   // operand captured even for write-only ops such as clear-file
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         opnd_r <= 8'h00;
      end else if (at_q2) begin
         opnd_r <= dif.uses_file ? rd_val : 8'h00;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         w_r <= 8'h00;
         c_r <= 1'b0;
         z_r <= 1'b0;
      end else if (at_q4 && live) begin
         if (do_wreg) begin
            w_r <= res;
         end
         if (upd_c) begin
            c_r <= res_c;
         end
         if (upd_z) begin
            z_r <= (res == 8'h00);
         end
      end
   end

   // registered outputs, all launched from flip-flops
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pc           <= '0;
         o_file_addr    <= 7'h00;
         o_file_rd      <= 1'b0;
         o_file_wr      <= 1'b0;
         o_file_wdata   <= 8'h00;
         o_port_read    <= 1'b0;
         o_prescale_clr <= 1'b0;
         o_wreg         <= 8'h00;
         o_carry        <= 1'b0;
         o_zero         <= 1'b0;
         o_class        <= 2'b00;
         o_skip_cycle   <= 1'b0;
         o_illegal      <= 1'b0;
         o_phase        <= 2'b00;
      end else begin
         o_pc           <= pc_r;
         o_file_addr    <= dif.faddr;
         o_file_rd      <= do_read;
         o_file_wr      <= do_write;
         o_file_wdata   <= res;
         o_port_read    <= do_read && is_port;
         o_prescale_clr <= do_write && !i_psa_to_wdt &&
                           (dif.faddr == `MRD_TIMER_ZERO_COUNT_ADDR);
         o_wreg         <= w_r;
         o_carry        <= c_r;
         o_zero         <= z_r;
         o_class        <= dif.cls;
         o_skip_cycle   <= flush_r;
         o_illegal      <= at_q4 && !flush_r && !dif.is_legal;
         o_phase        <= ph_r;
      end
   end
endmodule

// ### bench/mrd_prog_mem.sv
// program memory seen by the core; contents are loaded by the bench
module mrd_prog_mem #(
   parameter int PC_W = 13
) (
   // fetch port
   input  wire logic [PC_W-1:0] i_pc,
   output logic [13:0]          o_word
);
   timeunit 1ns;
   timeprecision 1ps;
   // 14-bit words only; small depth is enough for the bench programs
   logic [13:0] mem [0:15];
   // answers at once from the low pc bits; don't-care bits are as loaded
   assign o_word = mem[i_pc[3:0]];
endmodule

// ### bench/mrd_core_seq_assertions.sv
module mrd_core_seq_assertions #(
   parameter int PC_W = 13
) (
   input wire logic            i_clk,
   input wire logic            i_rst,
   input wire logic            i_psa_to_wdt,
   input wire logic [PC_W-1:0] o_pc,
   input wire logic [6:0]      o_file_addr,
   input wire logic            o_file_rd,
   input wire logic            o_file_wr,
   input wire logic            o_port_read,
   input wire logic            o_prescale_clr,
   input wire logic [7:0]      o_wreg,
   input wire logic            o_skip_cycle,
   input wire logic            o_illegal,
   input wire logic [1:0]      o_phase
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_phase_step;
      !$past(i_rst, 3) && !$past(i_rst, 2) && !$past(i_rst) |->
         o_phase == 2'($past(o_phase) + 2'd1);
   endproperty
   a_phase_step: assert property (p_phase_step) else $error("phase did not advance");
   property p_pc_hold;
      $changed(o_pc) |=> $stable(o_pc)[*3];
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc moved inside a cycle");
   property p_rd_once;
      o_file_rd |=> !o_file_rd[*3];
   endproperty
   a_rd_once: assert property (p_rd_once) else $error("two reads in one cycle");
   property p_rmw;
      o_file_wr |-> $past(o_file_rd, 2) && $stable(o_file_addr);
   endproperty
   a_rmw: assert property (p_rmw) else $error("write without prior read");
   property p_port_read;
      o_port_read |-> o_file_addr == 7'h06;
   endproperty
   a_port_read: assert property (p_port_read) else $error("port read off port");
   property p_prescale;
      o_prescale_clr |-> o_file_wr && o_file_addr == 7'h01 && !i_psa_to_wdt;
   endproperty
   a_prescale: assert property (p_prescale) else $error("bad prescaler clear");
   // the skip flag lags one edge, so it covers the read and write slots of the no-op cycle
   property p_flush_quiet;
      o_skip_cycle |-> !o_file_rd && !o_file_wr && !o_illegal;
   endproperty
   a_flush_quiet: assert property (p_flush_quiet) else $error("access in no-op cycle");
   // the next instruction may write four edges later, so only three are held quiet
   property p_illegal_nop;
      o_illegal |-> !o_file_wr ##1 !o_file_wr[*3];
   endproperty
   a_illegal_nop: assert property (p_illegal_nop) else $error("undefined word wrote");
   property p_reset_clean;
      disable iff (1'b0) $fell(i_rst) |-> !o_file_wr && !o_file_rd && o_wreg == 8'h00;
   endproperty
   a_reset_clean: assert property (p_reset_clean) else $error("outputs live at reset");
endmodule
bind mrd_core_seq mrd_core_seq_assertions #(.PC_W(PC_W)) mrd_core_seq_assertions_i (
   .i_clk(i_clk), .i_rst(i_rst), .i_psa_to_wdt(i_psa_to_wdt), .o_pc(o_pc),
   .o_file_addr(o_file_addr), .o_file_rd(o_file_rd), .o_file_wr(o_file_wr),
   .o_port_read(o_port_read), .o_prescale_clr(o_prescale_clr), .o_wreg(o_wreg),
   .o_skip_cycle(o_skip_cycle), .o_illegal(o_illegal), .o_phase(o_phase));

// ### bench/mid_range_instruction_decoder_test.sv
module mid_range_instruction_decoder_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk, i_rst, i_psa_to_wdt, o_file_rd, o_file_wr, o_port_read;
   logic        o_prescale_clr, o_carry, o_zero, o_skip_cycle, o_illegal;
   logic [13:0] i_instr;
   logic [12:0] o_pc;
   logic [7:0]  i_file_rdata, i_port_pins, o_file_wdata, o_wreg;
   logic [6:0]  o_file_addr;
   logic [1:0]  o_class, o_phase;
   logic [7:0]  fmem [0:127];
   logic [14:0] wq [$];
   int          err_total, n_checks, n_rd, n_port, n_pre, n_ill, n_bit, n_lit;
   mrd_core_seq mrd_core_seq_i (.i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr), .o_pc(o_pc),
      .i_file_rdata(i_file_rdata), .i_port_pins(i_port_pins), .i_psa_to_wdt(i_psa_to_wdt),
      .i_ret_addr(13'h0000), .o_file_addr(o_file_addr), .o_file_rd(o_file_rd),
      .o_file_wr(o_file_wr), .o_file_wdata(o_file_wdata), .o_port_read(o_port_read),
      .o_prescale_clr(o_prescale_clr), .o_wreg(o_wreg), .o_carry(o_carry), .o_zero(o_zero),
      .o_class(o_class), .o_skip_cycle(o_skip_cycle), .o_illegal(o_illegal), .o_phase(o_phase));
   mrd_prog_mem mrd_prog_mem_i (.i_pc(o_pc), .o_word(i_instr));
   // file model: read data follows the address, writes logged in order
   assign i_file_rdata = fmem[o_file_addr];
   always @(posedge i_clk) begin
      if (o_file_wr === 1'b1) begin
         fmem[o_file_addr] <= o_file_wdata;
         wq.push_back({o_file_addr, o_file_wdata});
      end
      n_rd += int'(o_file_rd === 1'b1);
      n_port += int'(o_port_read === 1'b1);
      n_pre += int'(o_prescale_clr === 1'b1);
      n_ill += int'(o_illegal === 1'b1);
      // class is counted once per read pulse and once per instruction cycle start
      n_bit += int'(o_file_rd === 1'b1 && o_class === 2'b01);
      n_lit += int'(o_class === 2'b11 && o_phase === 2'b00);
   end
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] set_bit(logic [7:0] v, logic [2:0] b);
      return v | (8'h01 << b);
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic run_prog(int t, bit xf, logic [7:0] k, logic [2:0] b);
      logic [7:0]  pins;
      logic [14:0] e [6];
      int          n;
      pins = 8'($urandom);
      // illegal option-load word at 1, skipped words at 9 and 11
      mrd_prog_mem_i.mem = '{14'h3000 | (xf ? 14'h0300 : 14'h0000) | 14'(k), 14'h0062,
         14'h00A0, 14'h0186, 14'h0081, 14'h1400 | {4'h0, b, 7'h20}, 14'h0806, 14'h00A1,
         14'h280A, 14'h00A2, 14'h1C00 | {4'h0, b, 7'h20}, 14'h00A3, 14'h00A4, 14'h280D,
         14'h0000, 14'h0000};
      e = '{{7'h20, k}, {7'h06, 8'h00}, {7'h01, k}, {7'h20, set_bit(k, b)},
            {7'h21, pins}, {7'h24, pins}};
      @(posedge i_clk) #1;
      i_rst = 1'b1;
      i_port_pins = pins;
      i_psa_to_wdt = 1'($urandom);
      foreach (fmem[i]) fmem[i] = 8'h00;
      repeat (20) @(posedge i_clk);
      wq.delete();
      n_rd = 0;
      n_port = 0;
      n_pre = 0;
      n_ill = 0;
      n_bit = 0;
      n_lit = 0;
      #1 i_rst = 1'b0;
      n = 0;
      while (o_pc !== 13'd13 && n < 400) begin
         @(posedge i_clk);
         n++;
      end
      if (n == 400) begin
         err_total++;
         report_and_stop();
      end
      repeat (40) @(posedge i_clk);
      chk("write count", 16'(wq.size()), 16'd6);
      for (int i = 0; i < 6; i++)
         chk("write", (i < wq.size()) ? 16'(wq[i]) : 16'hFFFF, 16'(e[i]));
      chk("reads", 16'(n_rd), 16'd8);
      chk("port reads", 16'(n_port), 16'd2);
      chk("prescale", 16'(n_pre), i_psa_to_wdt ? 16'd0 : 16'd1);
      chk("illegal", 16'(n_ill), 16'd1);
      chk("wreg", 16'(o_wreg), 16'(pins));
      // bit set and bit test read the file; only the first word is a literal
      chk("bit class reads", 16'(n_bit), 16'd2);
      chk("literal class", 16'(n_lit), 16'd1);
      // last zero update is the move of the port pins into the working register
      chk("zero flag", 16'(o_zero), 16'(pins == 8'h00));
      chk("carry flag", 16'(o_carry), 16'd0);
      $display("test %0d done", t);
   endtask
   initial begin
      i_rst = 1'b1;
      i_port_pins = 8'h00;
      i_psa_to_wdt = 1'b0;
      foreach (fmem[i]) fmem[i] = 8'h00;
      void'($urandom(32'hD8CE3089));
      // corners: top bit on zero data, bit zero on all ones, then random words
      run_prog(0, 1'b0, 8'h00, 3'd7);
      run_prog(1, 1'b1, 8'hFF, 3'd0);
      for (int t = 2; t < 8; t++) run_prog(t, 1'($urandom), 8'($urandom), 3'($urandom));
      report_and_stop();
   end
endmodule
